/* File: logic/interlock_pkg.sv */
// Package: constants and states for the checker interlock controller
package interlock_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 8;
  // Setup time between checker reset low and reconfigure pin low
  localparam int unsigned RST_LEAD_NS     = 80;
  localparam int unsigned RST_LEAD_CYC    =
    (RST_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 8;

  // ---------------------------------------------------------------------
  // Reset values of outputs
  // ---------------------------------------------------------------------
  localparam logic RST_EN_VAL    = 1'b0;
  localparam logic RST_START_VAL = 1'b0;
  localparam logic RST_RSTN_VAL  = 1'b0;

  // ---------------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_HOLD      = 4'b0000,  // After reset: checker held off
    ST_AUTH      = 4'b0001,  // Waiting for auth flag read
    ST_ENABLE    = 4'b0010,  // Enable high, start low
    ST_RUN       = 4'b0011,  // Checking
    ST_STOP      = 4'b0100,  // Start dropped, waiting busy low
    ST_DISABLE   = 4'b0101,  // Enable dropped
    ST_BG_OP     = 4'b0110,  // Config/program/flash granted
    ST_RST_LEAD  = 4'b0111,  // Checker reset low, lead time
    ST_RECONFIG  = 4'b1000   // Reconfigure/reload/reboot granted
  } state_e;

endpackage : interlock_pkg

/* File: logic/lead_timer.sv */
// Lead-time counter used before a reconfigure is released
`timescale 1ns/1ns
`default_nettype none
module lead_timer (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          run,
  output logic                               done
);
  // Lead length cut to the counter width on purpose
  localparam logic [interlock_pkg::CNT_W-1:0] LEAD_CYC =
    interlock_pkg::RST_LEAD_CYC[interlock_pkg::CNT_W-1:0];
  logic [interlock_pkg::CNT_W-1:0] cnt_q;
  logic [interlock_pkg::CNT_W-1:0] cnt_d;

  always_comb begin
    if (!run) begin
      cnt_d = '0;
    end else if (!done) begin
      cnt_d = cnt_q + 8'h01;
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q >= LEAD_CYC);
endmodule : lead_timer
`default_nettype wire

/* File: logic/checker_interlock.sv */
// Controller that sequences the soft-error checker around reconfiguration
//
// How it works
// - Checker reset goes low before or with the reconfigure pin going low.
// - Checker reset goes low before a reload command is issued.
// - Checker reset goes low before a software reboot is released.
// - External reconfigure grant is given only after checker reset is low.
// - Start is dropped first before any config or programming command.
// - After start drops, nothing further happens until busy reads low.
// - Enable drops after busy is low, and only then is the command granted.
// - Checking restarts only once the command transaction reports done.
// - With authentication, enable stays low until the auth flag is read.
// - Checking is stopped before any flash access is granted.
`timescale 1ns/1ns
`default_nettype none
module checker_interlock (
  input  wire logic MCLK_IN,
  input  wire logic SRST_IN,
  // User side
  input  wire logic AUTH_USED_IN,
  input  wire logic AUTH_READ_IN,
  input  wire logic CHECK_REQ_IN,
  input  wire logic BG_REQ_IN,
  input  wire logic BG_DONE_IN,
  input  wire logic RECONFIG_REQ_IN,
  output logic      BG_GRANT_OUT,
  output logic      RECONFIG_GRANT_OUT,
  output logic      CHECKING_OUT,
  // Checker side
  input  wire logic CHK_BUSY_IN,
  output logic      CHK_EN_OUT,
  output logic      CHK_START_OUT,
  output logic      CHK_RST_N_OUT,
  // Reconfigure pin, open drain: low enable means pulling low
  output logic      RECONFIG_PIN_N_OUT,
  output logic      RECONFIG_PIN_N_OE_N_OUT
);

  // -----------------------------------------------------------------------
  // State and output registers
  // -----------------------------------------------------------------------
  interlock_pkg::state_e state_q;
  interlock_pkg::state_e state_d;
  logic en_q;
  logic en_d;
  logic start_q;
  logic start_d;
  logic rstn_q;
  logic rstn_d;
  logic bg_q;
  logic bg_d;
  logic rcf_q;
  logic rcf_d;
  logic lead_done;
  logic lead_run;

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  // State match, shared by the lead timer and the status output
  function automatic logic in_state(
    input interlock_pkg::state_e cur,
    input interlock_pkg::state_e want
  );
    return (cur == want);
  endfunction : in_state

  // -----------------------------------------------------------------------
  // Reset lead timer
  // -----------------------------------------------------------------------
  // Timer clears outside the lead state, so every request gets a full lead
  assign lead_run = in_state(state_q, interlock_pkg::ST_RST_LEAD);

  lead_timer u_lead (
    .clk  (MCLK_IN),
    .srst (SRST_IN),
    .run  (lead_run),
    .done (lead_done)
  );

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    en_d    = en_q;
    start_d = start_q;
    rstn_d  = rstn_q;
    bg_d    = 1'b0;
    rcf_d   = 1'b0;
    case (state_q)
      interlock_pkg::ST_HOLD: begin
        // Release checker reset; enable and start stay low
        rstn_d = 1'b1;
        if (AUTH_USED_IN) begin
          state_d = interlock_pkg::ST_AUTH;
        end else begin
          state_d = interlock_pkg::ST_DISABLE;
        end
      end
      interlock_pkg::ST_AUTH: begin
        // Running the checker would wipe the flag before it is seen
        if (AUTH_READ_IN) begin
          state_d = interlock_pkg::ST_DISABLE;
        end
      end
      interlock_pkg::ST_DISABLE: begin
        en_d    = 1'b0;
        start_d = 1'b0;
        // Reconfigure first: a pending reload must not wait behind a check
        if (RECONFIG_REQ_IN) begin
          rstn_d  = 1'b0;
          state_d = interlock_pkg::ST_RST_LEAD;
        end else if (BG_REQ_IN) begin
          bg_d    = 1'b1;
          state_d = interlock_pkg::ST_BG_OP;
        end else if (CHECK_REQ_IN) begin
          en_d    = 1'b1;
          state_d = interlock_pkg::ST_ENABLE;
        end
      end
      interlock_pkg::ST_ENABLE: begin
        // Start one cycle after enable so the checker sees enable settled
        start_d = 1'b1;
        state_d = interlock_pkg::ST_RUN;
      end
      interlock_pkg::ST_RUN: begin
        if (BG_REQ_IN || RECONFIG_REQ_IN || !CHECK_REQ_IN) begin
          start_d = 1'b0;
          state_d = interlock_pkg::ST_STOP;
        end
      end
      interlock_pkg::ST_STOP: begin
        // No timeout: the checker always lets busy go once start is low
        if (!CHK_BUSY_IN) begin
          en_d    = 1'b0;
          state_d = interlock_pkg::ST_DISABLE;
        end
      end
      interlock_pkg::ST_BG_OP: begin
        // Grant stands until the user says the transaction is over
        bg_d = 1'b1;
        if (BG_DONE_IN) begin
          bg_d    = 1'b0;
          state_d = interlock_pkg::ST_DISABLE;
        end
      end
      interlock_pkg::ST_RST_LEAD: begin
        if (lead_done) begin
          rcf_d   = 1'b1;
          state_d = interlock_pkg::ST_RECONFIG;
        end
      end
      interlock_pkg::ST_RECONFIG: begin
        // Held until the request falls; a real reconfigure resets us anyway
        rcf_d = 1'b1;
        if (!RECONFIG_REQ_IN) begin
          rcf_d   = 1'b0;
          state_d = interlock_pkg::ST_HOLD;
        end
      end
      default: begin
        // Unknown code: fall back to the safe hold state, checker in reset
        state_d = interlock_pkg::ST_HOLD;
        en_d    = 1'b0;
        start_d = 1'b0;
        rstn_d  = 1'b0;
      end
    endcase
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      state_q <= interlock_pkg::ST_HOLD;
      en_q    <= interlock_pkg::RST_EN_VAL;
      start_q <= interlock_pkg::RST_START_VAL;
      rstn_q  <= interlock_pkg::RST_RSTN_VAL;
      bg_q    <= 1'b0;
      rcf_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      en_q    <= en_d;
      start_q <= start_d;
      rstn_q  <= rstn_d;
      bg_q    <= bg_d;
      rcf_q   <= rcf_d;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign CHK_EN_OUT              = en_q;
  assign CHK_START_OUT           = start_q;
  assign CHK_RST_N_OUT           = rstn_q;
  assign BG_GRANT_OUT            = bg_q;
  assign RECONFIG_GRANT_OUT      = rcf_q;
  assign CHECKING_OUT            = in_state(state_q, interlock_pkg::ST_RUN);

  // -----------------------------------------------------------------------
  // Reconfigure pin
  // -----------------------------------------------------------------------
  // Pin pulled low only when reset already low for the lead time
  assign RECONFIG_PIN_N_OUT      = 1'b0;
  assign RECONFIG_PIN_N_OE_N_OUT = ~(rcf_q & ~rstn_q);

endmodule : checker_interlock
`default_nettype wire

/* File: dv/checker_interlock_assertions.sv */
// Checker for the interlock controller ports
`timescale 1ns/1ns
`default_nettype none
module checker_interlock_sva (
  input wire logic MCLK_IN,
  input wire logic SRST_IN,
  input wire logic BG_DONE_IN,
  input wire logic CHK_BUSY_IN,
  input wire logic BG_GRANT_OUT,
  input wire logic RECONFIG_GRANT_OUT,
  input wire logic CHK_EN_OUT,
  input wire logic CHK_START_OUT,
  input wire logic CHK_RST_N_OUT,
  input wire logic RECONFIG_PIN_N_OE_N_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (SRST_IN);
  a_pin_after_rst: assert property (!RECONFIG_PIN_N_OE_N_OUT |->
    !CHK_RST_N_OUT) else $error("pin pulled with checker out of reset");
  a_grant_in_rst: assert property (RECONFIG_GRANT_OUT |->
    !CHK_RST_N_OUT) else $error("reconfig grant without checker reset");
  a_rst_lead: assert property ($rose(RECONFIG_GRANT_OUT) |->
    !$past(CHK_RST_N_OUT, 9)) else $error("reset lead too short");
  a_bg_quiet: assert property (BG_GRANT_OUT |->
    !CHK_EN_OUT && !CHK_START_OUT && !CHK_BUSY_IN)
    else $error("background grant while checker active");
  a_en_drop_idle: assert property ($fell(CHK_EN_OUT) &&
    CHK_RST_N_OUT |-> !CHK_BUSY_IN && !CHK_START_OUT)
    else $error("enable dropped while busy");
  a_start_needs_en: assert property (CHK_START_OUT &&
    CHK_RST_N_OUT |-> CHK_EN_OUT) else $error("start without enable");
  a_bg_hold: assert property (BG_GRANT_OUT && !BG_DONE_IN |=>
    BG_GRANT_OUT) else $error("grant dropped before done");
  a_restart_after: assert property ($rose(CHK_EN_OUT) |->
    !$past(BG_GRANT_OUT)) else $error("restart during transaction");
  c_bg: cover property ($rose(BG_GRANT_OUT));
  c_rcfg: cover property ($rose(RECONFIG_GRANT_OUT));
  c_busy: cover property ($fell(CHK_BUSY_IN));
endmodule : checker_interlock_sva
bind checker_interlock checker_interlock_sva i_sva (.*);
`default_nettype wire

/* File: dv/chk_model.sv */
// Behavioural model of the soft-error checker engine
`timescale 1ns/1ns
`default_nettype none
module chk_model #(parameter int SLOW = 3) (
  input  wire logic clk,
  input  wire logic en,
  input  wire logic start,
  input  wire logic rst_n,
  output logic      busy,
  output logic      auth_done
);
  int cnt;
  initial begin
    busy = 1'b0;
    auth_done = 1'b1;
    cnt = 0;
  end
  // Slow release so the controller really has to wait on busy
  always @(posedge clk) begin
    if (!rst_n || !en) begin
      busy <= 1'b0;
      cnt <= 0;
    end else if (start) begin
      busy <= 1'b1;
      cnt <= SLOW;
      auth_done <= 1'b0;
    end else if (cnt > 0) cnt <= cnt - 1;
    else busy <= 1'b0;
  end
endmodule : chk_model
`default_nettype wire

/* File: dv/test_checker_interlock.sv */
// Directed testbench for the interlock controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t got %b exp %b", $time, a, b); end end
`define WT(c) begin for (int k = 0; k < 99 && !(c); k++) begin \
  @(posedge clk); #1; end if (!(c)) miscompares++; end
module test_checker_interlock;
  logic clk, rst, au, ar, cr, bq, bd, rq, bg, rg, ck;
  logic busy, en, st, rn, pn, oe, ad;
  int miscompares = 0;
  int tests_run = 0;
  checker_interlock i_dut (.MCLK_IN(clk), .SRST_IN(rst),
    .AUTH_USED_IN(au), .AUTH_READ_IN(ar), .CHECK_REQ_IN(cr),
    .BG_REQ_IN(bq), .BG_DONE_IN(bd), .RECONFIG_REQ_IN(rq),
    .BG_GRANT_OUT(bg), .RECONFIG_GRANT_OUT(rg), .CHECKING_OUT(ck),
    .CHK_BUSY_IN(busy), .CHK_EN_OUT(en), .CHK_START_OUT(st),
    .CHK_RST_N_OUT(rn), .RECONFIG_PIN_N_OUT(pn),
    .RECONFIG_PIN_N_OE_N_OUT(oe));
  chk_model i_chk (.clk(clk), .en(en), .start(st), .rst_n(rn),
    .busy(busy), .auth_done(ad));
  task test_done;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #20000;
    miscompares++;
    test_done;
  end
  initial begin
    {ar, cr, bq, bd, rq} = 5'h00;
    au = 1'b1;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    cr = 1'b1;
    repeat (6) @(posedge clk);
    #1 `CHK(en, 1'b0)
    `CHK(ad, 1'b1)
    ar = 1'b1;
    @(posedge clk);
    #1 ar = 1'b0;
    au = 1'b0;
    `WT(st) `CHK(en, 1'b1)
    `CHK(ck, 1'b1)
    `WT(busy) `CHK(ad, 1'b0)
    bq = 1'b1;
    `WT(!st) `CHK(en, 1'b1)
    `CHK(ck, 1'b0)
    `WT(!en) `CHK(busy, 1'b0)
    `CHK(bg, 1'b0)
    `WT(bg) `CHK(st, 1'b0)
    repeat (3) @(posedge clk);
    #1 `CHK(en, 1'b0)
    bd = 1'b1;
    `WT(!bg) bd = 1'b0;
    bq = 1'b0;
    `WT(st) `CHK(bg, 1'b0)
    rq = 1'b1;
    `WT(!rn) `CHK(rg, 1'b0)
    `CHK(oe, 1'b1)
    `WT(rg) `CHK(rn, 1'b0)
    `CHK(oe, 1'b0)
    `CHK(pn, 1'b0)
    rq = 1'b0;
    `WT(rn) `CHK(oe, 1'b1)
    test_done;
  end
endmodule : test_checker_interlock
`default_nettype wire
